/* bench/mdp_host_model.sv */
// host model: drives the serial link pins and captures data out
`timescale 1ns/10ps
module mdp_host_model (
    output logic sclk,
    output logic cs_n,
    output logic sdi,
    input wire logic sdo_out
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end
    // ========
    // framed transfer
    // sclk stands low outside frames; sdo is sampled just before the
    // edge opposite the launch edge, so it sees a settled bit
    task automatic xfer(input logic [55:0] bits, input int n,
                        input logic fall_launch, output logic [55:0] got);
        got = '0;
        #7;
        cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            #12;
            sdi = bits[i];
            #12;
            if (fall_launch)
                got = {got[54:0], sdo_out};
            sclk = 1'b1;
            #24;
            if (!fall_launch)
                got = {got[54:0], sdo_out};
            sclk = 1'b0;
        end
        #24;
        cs_n = 1'b1;
        // released line must not keep showing the last bit
        sdi = ~sdi;
        #100;
    endtask
endmodule // mdp_host_model

/* bench/mdp_top_tb.sv */
// self-checking bench for the converter pin control
`timescale 1ns/10ps
`define CHK(nm, e, g) begin \
    tests_run++; \
    if ((g) !== (e)) begin \
        error_cnt++; \
        $display("[FAIL] %s exp %h got %h", nm, e, g); \
    end \
end
module mdp_top_tb import mdp_pkg::*;;
    logic ref_clk, srst, cyc, stb, we, ack;
    logic [31:0] adr, wdat, rdat_o, rd;
    logic [3:0] sel;
    logic sclk, cs_n, sdi, sdo_out, sdo_oe;
    logic [2:0] dith;
    logic ldn, clrn, rstn, alm_out, alm_oe;
    mdp_codes_t code;
    logic [55:0] got;
    int error_cnt, tests_run;
    localparam int PIN_LD = 3;
    localparam int PIN_CLR = 4;
    localparam int PIN_RST = 5;

    mdp_top u_mdp_top (.ref_clk(ref_clk), .srst(srst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat_o), .wb_ack_o(ack),
        .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo_out(sdo_out),
        .sdo_oe(sdo_oe), .dither_select_in_0(dith[0]),
        .dither_select_in_1(dith[1]), .dither_select_in_2(dith[2]),
        .sync_load_strobe_n(ldn), .output_clear_n(clrn),
        .reset_pin_n(rstn), .alarm_out_n_out(alm_out),
        .alarm_out_n_oe(alm_oe), .dac_code(code));
    mdp_host_model u_mdp_host_model (.sclk(sclk), .cs_n(cs_n),
        .sdi(sdi), .sdo_out(sdo_out));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // ========
    // helpers
    task automatic test_done;
        $display("errors %0d checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic cyc_wait(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // no fixed latency assumed: wait for ack, the watchdog bounds it
    task automatic wb(input logic w, input logic [31:0] a,
                      input logic [31:0] d);
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'h3;
        adr <= a;
        wdat <= d;
        @(posedge ref_clk);
        while (ack !== 1'b1)
            @(posedge ref_clk);
        rd = rdat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    // which: 0 to 2 select inputs, then strobe, clear, reset pin
    task automatic pin(input int which, input logic v);
        @(posedge ref_clk);
        case (which)
            PIN_LD: ldn <= v;
            PIN_CLR: clrn <= v;
            PIN_RST: rstn <= v;
            default: dith[which] <= v;
        endcase
        cyc_wait(5);
    endtask
    // ========
    // scenarios
    task automatic t_reset;
        `CHK("sdo_oe", 1'b0, sdo_oe)
        `CHK("alarm_oe", 1'b0, alm_oe)
        `CHK("codes", '0, code)
        wb(1'b0, 32'h4, 32'h0);
        `CHK("status", 32'h1, rd)
        wb(1'b1, 32'h200, 32'h1);
        wb(1'b0, 32'h200, 32'h0);
        `CHK("unmapped", 32'h0, rd)
    endtask
    task automatic t_direct;
        wb(1'b1, 32'h80, 32'h1234);
        cyc_wait(3);
        `CHK("grounded", 16'h0, code[0])
        wb(1'b1, 32'h0, 32'h4);
        cyc_wait(3);
        `CHK("direct", 16'h1234, code[0])
    endtask
    task automatic t_toggle;
        logic [31:0] ch;
        logic [15:0] ea, eb;
        for (int p = 0; p < 3; p++) begin
            ch = 32'(p + 1);
            ea = 16'(32'h1111 * ch);
            eb = 16'(32'h2222 * ch);
            wb(1'b1, 32'h40 + (ch << 2), {28'h0, 2'(p), 2'h2});
            wb(1'b1, 32'h80 + (ch << 2), {16'h0, ea});
            wb(1'b1, 32'hC0 + (ch << 2), {16'h0, eb});
            cyc_wait(5);
            `CHK("tog_a", ea, code[ch])
            pin(p, 1'b1);
            `CHK("tog_b", eb, code[ch])
            `CHK("direct_tog", 16'h1234, code[0])
            pin(p, 1'b0);
            `CHK("tog_a2", ea, code[ch])
        end
    endtask
    task automatic t_sync;
        wb(1'b1, 32'h50, 32'h1);
        wb(1'b1, 32'h90, 32'h4444);
        cyc_wait(5);
        `CHK("sync_held", 16'h0, code[4])
        pin(PIN_LD, 1'b0);
        `CHK("sync_load", 16'h4444, code[4])
        `CHK("direct_ld", 16'h1234, code[0])
        pin(PIN_LD, 1'b1);
        wb(1'b1, 32'h8, 32'hABCD);
        pin(PIN_CLR, 1'b0);
        for (int c = 0; c < 16; c++)
            `CHK("clear", 16'hABCD, code[c])
        pin(PIN_CLR, 1'b1);
        `CHK("unclear", 16'h1234, code[0])
    endtask
    task automatic t_serial;
        u_mdp_host_model.xfer({32'h0, 8'h25, 16'h5A5A}, 24, 1'b0, got);
        cyc_wait(10);
        `CHK("serial", 16'h5A5A, code[5])
        `CHK("no_alarm", 1'b0, alm_oe)
        u_mdp_host_model.xfer({32'h0, 8'h26, 16'h0F0F}, 23, 1'b0, got);
        cyc_wait(10);
        `CHK("short_drop", 16'h0, code[6])
        `CHK("alarm_oe", 1'b1, alm_oe)
        `CHK("alarm_lvl", 1'b0, alm_out)
        wb(1'b1, 32'h4, 32'h2);
        cyc_wait(2);
        `CHK("alarm_clr", 1'b0, alm_oe)
    endtask
    task automatic t_sdo;
        // trailer is a read frame, so no write; 56 bits count as 24 on the 5-bit counter, so no alarm
        for (int e = 0; e < 2; e++) begin
            wb(1'b1, 32'h0, {29'h0, 1'b1, 1'(e), 1'b1});
            cyc_wait(1);
            `CHK("serial_output_enable_bit", 1'b1, sdo_oe)
            u_mdp_host_model.xfer(56'h800000, 24, 1'(e), got);
            u_mdp_host_model.xfer({32'hC35A96E1, 24'h800000}, 56,
                                  1'(e), got);
            `CHK("sdo_bits", 32'hC35A96E1, got[31:0])
        end
        `CHK("read_alarm", 1'b0, alm_oe)
    endtask
    task automatic t_pin_reset;
        pin(PIN_RST, 1'b0);
        pin(PIN_RST, 1'b1);
        `CHK("rst_sdo", 1'b0, sdo_oe)
        `CHK("rst_codes", '0, code)
        wb(1'b0, 32'h4, 32'h0);
        `CHK("rst_status", 32'h1, rd)
    endtask
    // ========
    // main sequence
    initial begin
        error_cnt = 0;
        tests_run = 0;
        srst = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 32'h0;
        wdat = 32'h0;
        sel = 4'h3;
        dith = 3'h0;
        ldn = 1'b1;
        clrn = 1'b1;
        rstn = 1'b0;
        repeat (5) @(posedge ref_clk);
        srst <= 1'b0;
        rstn <= 1'b1;
        cyc_wait(5);
        t_reset;
        t_direct;
        t_toggle;
        t_sync;
        t_serial;
        t_sdo;
        t_pin_reset;
        test_done;
    end
    initial begin
        #200000;
        error_cnt++;
        $display("[FAIL] watchdog exp done got timeout");
        test_done;
    end
endmodule // mdp_top_tb

/* hw/mdp_link.sv */
// serial link logic on the serial clock: input shift and data out
`timescale 1ns/10ps
module mdp_link import mdp_pkg::*; (
    input wire logic sclk,
    input wire logic link_rst_n,
    input wire logic cs_n,
    input wire logic sdi,
    input wire logic edge_sel,
    output logic sdo_out,
    output mdp_frame_t frame
);
    typedef struct packed {
        logic [23:0] word;
        logic [4:0] cnt;
    } mdp_lk_t;
    mdp_lk_t s_reg, s_next;
    logic sdo_rise_reg;
    logic edge_s;
    // config only settles after two serial clocks; set it between frames
    mdp_sync2 #(.W(1), .RST(1'b0)) u_edge (
        .clk(sclk),
        .srst(1'b0),
        .d(edge_sel),
        .q(edge_s)
    );
    // ==========================================================
    // input shift, falling edge, only while selected
    always_comb begin
        s_next = s_reg;
        if (!cs_n) begin
            s_next.word = {s_reg.word[22:0], sdi};
            s_next.cnt = s_reg.cnt + 5'h01;
        end
    end
    always_ff @(negedge sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
    // ==========================================================
    // output launch edge
    always_ff @(posedge sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            sdo_rise_reg <= 1'b0;
        end else begin
            sdo_rise_reg <= s_reg.word[FR_RD];
        end
    end
    // falling launch: the msb appears right after the shifting edge
    assign sdo_out = edge_s ? s_reg.word[FR_RD] : sdo_rise_reg;
    assign frame.word = s_reg.word;
    assign frame.cnt = s_reg.cnt;
endmodule // mdp_link

/* hw/mdp_pkg.sv */
// shared constants and types for the multichannel converter pin control
package mdp_pkg;
    // ==========================================================
    // sizes
    localparam int NCH = 16;
    localparam int DW = 16;
    localparam logic [4:0] FRAME_LEN = 5'h18;
    localparam int FR_RD = 23;
    localparam int FR_IDX_HI = 22;
    localparam int FR_IDX_LO = 16;
    localparam int ADR_HI = 8;
    localparam int ADR_LO = 2;
    // ==========================================================
    // register word indices (byte address = index * 4)
    localparam logic [2:0] BANK_MISC = 3'h0;
    localparam logic [2:0] BANK_MODE = 3'h1;
    localparam logic [2:0] BANK_A = 3'h2;
    localparam logic [2:0] BANK_B = 3'h3;
    localparam logic [2:0] BANK_OUT = 3'h4;
    localparam logic [3:0] IDX_CTRL = 4'h0;
    localparam logic [3:0] IDX_STATUS = 4'h1;
    localparam logic [3:0] IDX_CLEAR = 4'h2;
    localparam int STAT_HOLD = 0;
    localparam int STAT_ALARM = 1;
    // ==========================================================
    // reset values
    localparam logic [15:0] CLEAR_CODE_RST = 16'h0000;
    localparam logic [6:0] PIN_SYNC_RST = 7'h78;
    // ==========================================================
    // types
    typedef enum logic [1:0] {
        KIND_ASYNC = 2'h0,
        KIND_SYNC = 2'h1,
        KIND_TOGGLE = 2'h2,
        KIND_RSVD = 2'h3
    } mdp_kind_t;
    typedef struct packed {
        logic [1:0] pin;
        mdp_kind_t kind;
    } mdp_mode_t;
    typedef struct packed {
        logic cfg;
        logic edge_sel;
        logic serial_output_enable_bit;
    } mdp_ctrl_t;
    typedef struct packed {
        logic [23:0] word;
        logic [4:0] cnt;
    } mdp_frame_t;
    typedef logic [15:0][15:0] mdp_codes_t;
endpackage

/* hw/mdp_sync2.sv */
// two-flop level synchroniser, parameterised width and reset value
`timescale 1ns/10ps
module mdp_sync2 import mdp_pkg::*; #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] m1;
        logic [W-1:0] m2;
    } mdp_sync_t;
    mdp_sync_t s_reg, s_next;
    always_comb begin
        s_next.m1 = d;
        s_next.m2 = s_reg.m1;
        if (srst) begin
            s_next.m1 = RST;
            s_next.m2 = RST;
        end
    end
    always_ff @(posedge clk) begin
        s_reg <= s_next;
    end
    assign q = s_reg.m2;
endmodule // mdp_sync2

/* hw/mdp_top.sv */
// multichannel converter pin control: bus slave, channels, pins
// Operation
// - data out stays disabled until enabled
// - shift register contents go out on data out
// - launch on rising edge, or falling if selected
// - capture data in at each falling edge
// - shift register works only while selected
// - toggle channels follow A low, B high
// - load strobe low updates synchronous channels together
// - reset pin low repeats the power-on reset
// - clear pin low forces the clear code
// - alarm output only pulls low
// - outputs grounded until software configures device
`timescale 1ns/10ps
module mdp_top import mdp_pkg::*; (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    output logic sdo_out,
    output logic sdo_oe,
    input wire logic dither_select_in_0,
    input wire logic dither_select_in_1,
    input wire logic dither_select_in_2,
    input wire logic sync_load_strobe_n,
    input wire logic output_clear_n,
    input wire logic reset_pin_n,
    output logic alarm_out_n_out,
    output logic alarm_out_n_oe,
    output mdp_codes_t dac_code
);
    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        mdp_ctrl_t ctrl;
        logic alarm;
        logic csn_d;
        logic [4:0] cnt_prev;
        logic [15:0] clr_code;
        mdp_mode_t [15:0] mode;
        mdp_codes_t a;
        mdp_codes_t b;
        mdp_codes_t out;
    } mdp_state_t;
    mdp_state_t s_reg, s_next;
    mdp_frame_t link_frame;
    logic [6:0] pins_s;
    logic rst_s, clr_s, sync_load_strobe_n_s, csn_s;
    logic [2:0] tog_s;
    logic frame_end, spi_wr, wb_req, wr_en, hold;
    logic [4:0] nbits;
    logic [6:0] wr_idx;
    logic [15:0] wr_dat, wr_mask;
    logic [1:0] wr_sel;
    logic [3:0] wr_ch, rd_ch;
    logic [31:0] rd_val;
    logic [3:0] tog_ext;
    logic ctrl_wr;
    // ==========================================================
    // pin synchronisers
    mdp_sync2 #(.W(7), .RST(PIN_SYNC_RST)) u_pins (
        .clk(ref_clk),
        .srst(srst),
        .d({reset_pin_n, output_clear_n, sync_load_strobe_n, cs_n,
            dither_select_in_2, dither_select_in_1, dither_select_in_0}),
        .q(pins_s)
    );
    assign rst_s = pins_s[6];
    assign clr_s = pins_s[5];
    assign sync_load_strobe_n_s = pins_s[4];
    assign csn_s = pins_s[3];
    assign tog_s = pins_s[2:0];
    // pin code 3 selects a constant low input
    assign tog_ext = {1'b0, tog_s};
    // ==========================================================
    // serial link domain
    // the raw reset pin also clears the link side, which has no other
    // edge select is resynchronised inside, on the serial clock
    mdp_link u_link (
        .sclk(sclk),
        .link_rst_n(reset_pin_n),
        .cs_n(cs_n),
        .sdi(sdi),
        .edge_sel(s_reg.ctrl.edge_sel),
        .sdo_out(sdo_out),
        .frame(link_frame)
    );
    // ==========================================================
    // read mux
    always_comb begin
        rd_ch = wb_adr_i[5:2];
        rd_val = 32'h00000000;
        if (wb_adr_i[31:ADR_HI+1] == '0) begin
            case (wb_adr_i[ADR_HI:ADR_LO+4])
                BANK_MISC: begin
                    if (rd_ch == IDX_CTRL) begin
                        rd_val[2:0] = s_reg.ctrl;
                    end else if (rd_ch == IDX_STATUS) begin
                        rd_val[STAT_HOLD] = hold;
                        rd_val[STAT_ALARM] = s_reg.alarm;
                    end else if (rd_ch == IDX_CLEAR) begin
                        rd_val[15:0] = s_reg.clr_code;
                    end
                end
                BANK_MODE: rd_val[3:0] = s_reg.mode[rd_ch];
                BANK_A: rd_val[15:0] = s_reg.a[rd_ch];
                BANK_B: rd_val[15:0] = s_reg.b[rd_ch];
                BANK_OUT: rd_val[15:0] = s_reg.out[rd_ch];
                default: rd_val = 32'h00000000;
            endcase
        end
    end
    // ==========================================================
    // next state
    assign hold = ~s_reg.ctrl.cfg;
    assign ctrl_wr = wr_en & wr_sel[0] & (wr_idx == {BANK_MISC, IDX_CTRL});
    always_comb begin
        s_next = s_reg;
        s_next.ack = 1'b0;
        s_next.csn_d = csn_s;
        // the link side is quiet while chip select is high,
        // so frame word and count stand still when read here
        frame_end = csn_s & ~s_reg.csn_d;
        nbits = link_frame.cnt - s_reg.cnt_prev;
        spi_wr = frame_end & (nbits == FRAME_LEN)
            & ~link_frame.word[FR_RD];
        // a serial write takes the cycle; the bus waits one more
        wb_req = wb_cyc_i & wb_stb_i & ~s_reg.ack & ~spi_wr;
        wr_en = spi_wr
            | (wb_req & wb_we_i & (wb_adr_i[31:ADR_HI+1] == '0));
        wr_idx = spi_wr ? link_frame.word[FR_IDX_HI:FR_IDX_LO]
            : wb_adr_i[ADR_HI:ADR_LO];
        wr_dat = spi_wr ? link_frame.word[15:0] : wb_dat_i[15:0];
        wr_sel = spi_wr ? 2'h3 : wb_sel_i[1:0];
        wr_mask = {{8{wr_sel[1]}}, {8{wr_sel[0]}}};
        wr_ch = wr_idx[3:0];
        if (wb_req) begin
            s_next.ack = 1'b1;
            s_next.rdat = rd_val;
        end
        if (wr_en) begin
            case (wr_idx[6:4])
                BANK_MISC: begin
                    if (wr_ch == IDX_CTRL && wr_sel[0]) begin
                        s_next.ctrl = wr_dat[2:0];
                    end else if (wr_ch == IDX_STATUS && wr_sel[0]
                        && wr_dat[STAT_ALARM]) begin
                        s_next.alarm = 1'b0;
                    end else if (wr_ch == IDX_CLEAR) begin
                        s_next.clr_code = (s_reg.clr_code & ~wr_mask)
                            | (wr_dat & wr_mask);
                    end
                end
                BANK_MODE: begin
                    if (wr_sel[0]) begin
                        s_next.mode[wr_ch] = wr_dat[3:0];
                    end
                end
                BANK_A: s_next.a[wr_ch] = (s_reg.a[wr_ch] & ~wr_mask)
                    | (wr_dat & wr_mask);
                BANK_B: s_next.b[wr_ch] = (s_reg.b[wr_ch] & ~wr_mask)
                    | (wr_dat & wr_mask);
                default: s_next.ctrl = s_reg.ctrl;
            endcase
        end
        // frame accounting after the clear, so a new error wins
        if (frame_end) begin
            s_next.cnt_prev = link_frame.cnt;
            if (nbits != FRAME_LEN) begin
                s_next.alarm = 1'b1;
            end
        end
        // channel outputs
        for (int i = 0; i < NCH; i++) begin
            case (s_reg.mode[i].kind)
                KIND_SYNC: begin
                    if (!sync_load_strobe_n_s) begin
                        s_next.out[i] = s_reg.a[i];
                    end
                end
                KIND_TOGGLE: begin
                    // pin code 3 has no input and reads as low
                    if (tog_ext[s_reg.mode[i].pin]) begin
                        s_next.out[i] = s_reg.b[i];
                    end else begin
                        s_next.out[i] = s_reg.a[i];
                    end
                end
                default: s_next.out[i] = s_reg.a[i];
            endcase
            if (!clr_s) begin
                s_next.out[i] = s_reg.clr_code;
            end
            if (hold) begin
                s_next.out[i] = 16'h0000;
            end
        end
        if (srst || !rst_s) begin
            s_next = '0;
            s_next.csn_d = 1'b1;
            s_next.clr_code = CLEAR_CODE_RST;
            s_next.cnt_prev = link_frame.cnt;
        end
    end
    always_ff @(posedge ref_clk) begin
        s_reg <= s_next;
    end
    // ==========================================================
    // outputs
    assign wb_ack_o = s_reg.ack;
    assign wb_dat_o = s_reg.rdat;
    assign sdo_oe = s_reg.ctrl.serial_output_enable_bit;
    assign alarm_out_n_out = 1'b0;
    assign alarm_out_n_oe = s_reg.alarm;
    assign dac_code = s_reg.out;
    // ==========================================================
    // checks
    sdo_off_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        $rose(sdo_oe) |-> ($past(ctrl_wr) && $past(wr_dat[0])))
        else $error("data out enabled without enable bit");
    por_ground_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        hold |=> (dac_code == '0))
        else $error("outputs not grounded while unconfigured");
    clear_code_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        (!clr_s && !hold && rst_s) |=>
        (dac_code[0] == $past(s_reg.clr_code))
        && (dac_code[15] == $past(s_reg.clr_code)))
        else $error("clear did not force clear code");
    toggle_sel_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        (s_reg.mode[2].kind == KIND_TOGGLE && s_reg.mode[2].pin == 2'h1
        && clr_s && !hold && rst_s) |=>
        (dac_code[2] == ($past(tog_s[1]) ? $past(s_reg.b[2])
        : $past(s_reg.a[2]))))
        else $error("toggle channel took wrong register");
    toggle_pin2_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        (s_reg.mode[3].kind == KIND_TOGGLE && s_reg.mode[3].pin == 2'h2
        && clr_s && !hold && rst_s) |=>
        (dac_code[3] == ($past(tog_s[2]) ? $past(s_reg.b[3])
        : $past(s_reg.a[3]))))
        else $error("toggle channel took wrong register");
    sync_stay_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        (s_reg.mode[4].kind == KIND_SYNC && sync_load_strobe_n_s && clr_s && !hold
        && rst_s) |=> $stable(dac_code[4]))
        else $error("sync channel moved without load strobe");
    sync_load_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        (s_reg.mode[4].kind == KIND_SYNC && !sync_load_strobe_n_s && clr_s && !hold
        && rst_s) |=> (dac_code[4] == $past(s_reg.a[4])))
        else $error("sync channel not loaded on strobe");
    direct_upd_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        (s_reg.mode[0].kind == KIND_ASYNC && clr_s && !hold && rst_s)
        |=> (dac_code[0] == $past(s_reg.a[0])))
        else $error("direct channel did not follow data");
    alarm_set_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        (frame_end && nbits != FRAME_LEN && rst_s) |=>
        (alarm_out_n_oe && !alarm_out_n_out))
        else $error("bad frame did not pull alarm low");
    reset_pin_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        !rst_s |=> (s_reg.ctrl == '0 && !alarm_out_n_oe && !wb_ack_o))
        else $error("reset pin did not reset device");
    ack_pulse_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    // bus bookkeeping: one answer per request, data held in between
    ack_answer_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        (wb_req && rst_s) |=> wb_ack_o)
        else $error("bus request not answered");
    rdat_hold_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        (!wb_req && rst_s) |=> $stable(wb_dat_o))
        else $error("read data moved without a request");
    alarm_keep_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        (alarm_out_n_oe && !wr_en && rst_s) |=> alarm_out_n_oe)
        else $error("alarm released without a clear");
    serial_wr_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        (spi_wr && wr_idx[6:4] == BANK_A && rst_s) |=>
        (s_reg.a[$past(wr_ch)] == $past(wr_dat)))
        else $error("serial frame did not write data A");
    reset_codes_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        !rst_s |=> (dac_code == '0))
        else $error("reset pin left a channel code");
endmodule // mdp_top
